// ### common/asp_cfg.svh
/*
  Constants of the asynchronous serial port: widths, reset values, counts.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_DATA_W 9
`define ASP_FIFO_DEPTH 16
`define ASP_CNT_W 5
`define ASP_RELOAD_W 15
`define ASP_LEN_BASE 4'h5
`define ASP_LEN_MAX 4'h9
`define ASP_IDLE_TICKS 4'h8
`define ASP_TX_EMPTY_RST 1'b1
`define ASP_FIFO_REQ_RST 1'b1
`define ASP_LINE_IDLE 1'b1
`endif

// ### common/asp_pkg.sv
/*
  Types of the asynchronous serial port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package asp_pkg;
  // frame phase, shared by transmitter and receiver
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP1, ST_STOP2
  } asp_state_t;
endpackage : asp_pkg

// ### hdl/asp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and an occupancy count.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
  parameter int W = 9,
  parameter int D = 16,
  parameter int CW = 5
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [CW-1:0] count_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  // ready reflects real space, so a stalled reader fills it to the brim
  assign in_ready_out = (cnt_q != CW'(D));
  assign out_valid_out = (cnt_q != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;
  assign out_data_out = mem[rd_q];
  assign count_out = cnt_q;

  // storage is written without reset; only pointers and count carry state
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || flush_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule : asp_fifo
`default_nettype wire

// ### hdl/asp_top.sv
/*
  Asynchronous serial transmitter and receiver with 16-word FIFOs.
  Assumes all inputs synchronous to mclk_in and strobes one cycle long.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asp_cfg.svh"
module asp_top (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [`ASP_RELOAD_W-1:0] reload_val_in,
  input wire logic tx_enable_in,
  input wire logic rx_enable_in,
  input wire logic [2:0] data_length_field_in,
  input wire logic two_stop_in,
  input wire logic parity_enable_in,
  input wire logic parity_odd_in,
  input wire logic multiproc_in,
  input wire logic tx_ad_flag_in,
  input wire logic bit_direction_select_in,
  input wire logic line_inversion_in,
  input wire logic tx_fifo_enable_in,
  input wire logic rx_fifo_enable_in,
  input wire logic rx_fifo_idle_detect_enable_in,
  input wire logic [`ASP_CNT_W-1:0] rx_transfer_count_in,
  input wire logic tx_irq_enable_in,
  input wire logic tx_idle_irq_enable_in,
  input wire logic fifo_tx_irq_enable_in,
  input wire logic rx_irq_enable_in,
  input wire logic tx_wr_in,
  input wire logic [`ASP_DATA_W-1:0] tx_data_in,
  output logic tx_wr_ready_out,
  input wire logic rx_rd_in,
  input wire logic rx_error_clear_in,
  input wire logic fifo_tx_request_clear_in,
  input wire logic serial_in_line_in,
  output logic serial_out_line_out,
  output logic [`ASP_DATA_W-1:0] rx_data_reg_out,
  output logic rx_ad_flag_out,
  output logic tx_empty_flag_out,
  output logic tx_bus_idle_flag_out,
  output logic fifo_tx_request_flag_out,
  output logic rx_full_flag_out,
  output logic overrun_flag_out,
  output logic framing_error_flag_out,
  output logic parity_error_flag_out,
  output logic [`ASP_CNT_W-1:0] tx_fifo_byte_count_out,
  output logic [`ASP_CNT_W-1:0] rx_fifo_byte_count_out,
  output logic tx_irq_out,
  output logic rx_irq_out
);
  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  logic [3:0] len;
  logic [8:0] len_mask;
  logic par_on;
  logic ferr_q, perr_q, ore_q, full_q, tx_empty_flag_q, tbi_q, fifo_tx_request_flag_q;
  logic [`ASP_DATA_W-1:0] rx_data_q;
  logic rx_ad_q, sot_q, tx_irq_q, rx_irq_q;
  logic [`ASP_CNT_W-1:0] txc_q, rxc_q;

  assign len = (data_length_field_in > 3'h4) ? `ASP_LEN_MAX :
               4'(`ASP_LEN_BASE + {1'b0, data_length_field_in});
  assign par_on = parity_enable_in & ~multiproc_in;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      len_mask[i] = (4'(i) < len);
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  asp_pkg::asp_state_t tx_st_q;
  logic [`ASP_RELOAD_W-1:0] tx_bc_q;
  logic tx_tick, tx_load, tx_fv, tx_fr, tx_push;
  logic [`ASP_DATA_W-1:0] tx_fd, tx_sh_q;
  logic [`ASP_CNT_W-1:0] tx_cnt;
  logic [3:0] tx_n_q, tx_idx;
  logic tx_par_q, tx_bit;

  // without the FIFO the queue acts as a one-word data register
  assign tx_fr = tx_fifo_enable_in ? (tx_cnt != 5'(`ASP_FIFO_DEPTH)) :
                 (tx_cnt == '0);
  assign tx_push = tx_wr_in & tx_fr;
  assign tx_load = (tx_st_q == asp_pkg::ST_IDLE) & tx_enable_in & tx_fv;

  asp_fifo #(.W(`ASP_DATA_W), .D(`ASP_FIFO_DEPTH), .CW(`ASP_CNT_W)) u_txf (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .flush_in(1'b0),
    .in_valid_in(tx_push), .in_ready_out(),
    .in_data_in(tx_data_in),
    .out_valid_out(tx_fv), .out_ready_in(tx_load),
    .out_data_out(tx_fd), .count_out(tx_cnt)
  );

  // bit clock restarts on load so the start bit is a full bit long
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || tx_load || tx_bc_q == '0) begin
      tx_bc_q <= reload_val_in;
    end else begin
      tx_bc_q <= tx_bc_q - 1'b1;
    end
  end
  assign tx_tick = (tx_bc_q == '0) & (reload_val_in != '0);

  assign tx_idx = bit_direction_select_in ? 4'(len - 4'h1 - tx_n_q) : tx_n_q;
  assign tx_bit = tx_sh_q[tx_idx];

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tx_st_q <= asp_pkg::ST_IDLE;
      tx_n_q <= 4'h0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
    end else if (tx_load) begin
      tx_st_q <= asp_pkg::ST_START;
      tx_n_q <= 4'h0;
      tx_sh_q <= tx_fd & len_mask;
      // even or odd parity; flag in its place
      tx_par_q <= multiproc_in ? tx_ad_flag_in :
                  (^(tx_fd & len_mask)) ^ parity_odd_in;
    end else if (tx_tick) begin
      unique case (tx_st_q)
        asp_pkg::ST_IDLE: tx_st_q <= asp_pkg::ST_IDLE;
        asp_pkg::ST_START: tx_st_q <= asp_pkg::ST_DATA;
        asp_pkg::ST_DATA: begin
          tx_n_q <= 4'(tx_n_q + 4'h1);
          if (tx_n_q == 4'(len - 4'h1)) begin
            tx_st_q <= (par_on | multiproc_in) ? asp_pkg::ST_PAR :
                       asp_pkg::ST_STOP1;
          end
        end
        asp_pkg::ST_PAR: tx_st_q <= asp_pkg::ST_STOP1;
        asp_pkg::ST_STOP1: tx_st_q <= two_stop_in ? asp_pkg::ST_STOP2 :
                                       asp_pkg::ST_IDLE;
        asp_pkg::ST_STOP2: tx_st_q <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sot_q <= `ASP_LINE_IDLE;
    end else begin
      unique case (tx_st_q)
        asp_pkg::ST_START: sot_q <= 1'b0 ^ line_inversion_in;
        asp_pkg::ST_DATA: sot_q <= tx_bit ^ line_inversion_in;
        asp_pkg::ST_PAR: sot_q <= tx_par_q ^ line_inversion_in;
        default: sot_q <= `ASP_LINE_IDLE ^ line_inversion_in;
      endcase
    end
  end

  // empty flag resets set; set on load wins
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tx_empty_flag_q <= `ASP_TX_EMPTY_RST;
    end else if (tx_load) begin
      tx_empty_flag_q <= 1'b1;
    end else if (tx_push) begin
      tx_empty_flag_q <= 1'b0;
    end
  end

  // idle once empty and nothing in flight
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tbi_q <= 1'b1;
    end else begin
      tbi_q <= tx_empty_flag_q & ~tx_push & ~tx_fv & ~tx_load &
               (tx_st_q == asp_pkg::ST_IDLE);
    end
  end

  // request resets set; empty sets it over the clear
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      fifo_tx_request_flag_q <= `ASP_FIFO_REQ_RST;
    end else if (tx_fifo_enable_in && tx_cnt == '0) begin
      fifo_tx_request_flag_q <= 1'b1;
    end else if (tx_cnt == 5'(`ASP_FIFO_DEPTH) || fifo_tx_request_clear_in) begin
      fifo_tx_request_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  asp_pkg::asp_state_t rx_st_q;
  logic [`ASP_RELOAD_W-1:0] rx_bc_q;
  logic [`ASP_DATA_W-1:0] rx_sh_q, rx_fd;
  logic [3:0] rx_n_q, rx_idx, idle_q;
  logic rx_line, rx_prev_q, rx_fall, rx_tick, rx_par_q;
  logic done, f_err, p_err, rx_push, rx_pop, rx_fv, err_any;
  logic [`ASP_CNT_W-1:0] rx_cnt;

  // inverted coding on the input too
  assign rx_line = serial_in_line_in ^ line_inversion_in;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rx_prev_q <= `ASP_LINE_IDLE;
    end else begin
      rx_prev_q <= rx_line;
    end
  end
  // only a falling edge starts a frame
  assign rx_fall = rx_prev_q & ~rx_line & rx_enable_in &
                   (rx_st_q == asp_pkg::ST_IDLE);

  // edge reloads at half a bit so samples land mid-bit
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rx_bc_q <= '0;
    end else if (rx_fall) begin
      rx_bc_q <= reload_val_in >> 1;
    end else if (rx_bc_q == '0) begin
      rx_bc_q <= reload_val_in;
    end else begin
      rx_bc_q <= rx_bc_q - 1'b1;
    end
  end
  assign rx_tick = (rx_bc_q == '0) & (reload_val_in != '0) &
                   (rx_st_q != asp_pkg::ST_IDLE);

  assign rx_idx = bit_direction_select_in ? 4'(len - 4'h1 - rx_n_q) : rx_n_q;
  assign done = rx_tick & (rx_st_q == asp_pkg::ST_STOP1);
  assign f_err = ~rx_line;
  // compare against parity of received data
  assign p_err = par_on & (rx_par_q != ((^rx_sh_q) ^ parity_odd_in));

  // receiver: second stop bit is not checked, a new edge may follow
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rx_st_q <= asp_pkg::ST_IDLE;
      rx_n_q <= 4'h0;
      rx_sh_q <= '0;
      rx_par_q <= 1'b0;
    end else if (rx_fall) begin
      rx_st_q <= asp_pkg::ST_START;
      rx_n_q <= 4'h0;
      rx_sh_q <= '0;
    end else if (rx_tick) begin
      unique case (rx_st_q)
        asp_pkg::ST_IDLE: rx_st_q <= asp_pkg::ST_IDLE;
        // glitch shorter than half a bit is dropped
        asp_pkg::ST_START: rx_st_q <= rx_line ? asp_pkg::ST_IDLE :
                                      asp_pkg::ST_DATA;
        asp_pkg::ST_DATA: begin
          rx_sh_q[rx_idx] <= rx_line;
          rx_n_q <= 4'(rx_n_q + 4'h1);
          if (rx_n_q == 4'(len - 4'h1)) begin
            rx_st_q <= (par_on | multiproc_in) ? asp_pkg::ST_PAR :
                       asp_pkg::ST_STOP1;
          end
        end
        asp_pkg::ST_PAR: begin
          rx_par_q <= rx_line;
          rx_st_q <= asp_pkg::ST_STOP1;
        end
        asp_pkg::ST_STOP1: rx_st_q <= asp_pkg::ST_IDLE;
        asp_pkg::ST_STOP2: rx_st_q <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive storage and flags
  // ---------------------------------------------------------------
  assign err_any = ferr_q | perr_q | ore_q;
  // with the FIFO on, errored frames and a halted FIFO store nothing
  assign rx_push = done & (rx_fifo_enable_in ?
                   (~err_any & ~f_err & ~p_err &
                    (rx_cnt != 5'(`ASP_FIFO_DEPTH))) :
                   ~full_q);
  assign rx_pop = rx_rd_in & rx_fv;

  asp_fifo #(.W(`ASP_DATA_W), .D(`ASP_FIFO_DEPTH), .CW(`ASP_CNT_W)) u_rxf (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .flush_in(1'b0),
    .in_valid_in(rx_push), .in_ready_out(),
    .in_data_in(rx_sh_q),
    .out_valid_out(rx_fv), .out_ready_in(rx_pop),
    .out_data_out(rx_fd), .count_out(rx_cnt)
  );

  // idle baud clocks counted on the free-running bit clock
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || !rx_fifo_enable_in || rx_rd_in || done ||
        rx_st_q != asp_pkg::ST_IDLE) begin
      idle_q <= 4'h0;
    end else if (tx_tick && rx_fifo_idle_detect_enable_in && rx_cnt != '0 &&
                 rx_cnt < rx_transfer_count_in &&
                 idle_q != `ASP_IDLE_TICKS) begin
      idle_q <= 4'(idle_q + 4'h1);
    end
  end

  // receive full: sets other than the idle timeout win over the clearing read
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      full_q <= 1'b0;
    end else if (done && !rx_fifo_enable_in) begin
      // first stop bit; even when framing fails
      full_q <= 1'b1;
    end else if (done && rx_fifo_enable_in && !err_any &&
                 rx_cnt == 5'(`ASP_FIFO_DEPTH)) begin
      // overrun at capacity also sets it
      full_q <= 1'b1;
    end else if (rx_push && 5'(rx_cnt + 5'h1) >= rx_transfer_count_in) begin
      full_q <= 1'b1;
    end else if (idle_q == `ASP_IDLE_TICKS - 4'h1 && tx_tick &&
                 rx_fifo_idle_detect_enable_in && rx_st_q == asp_pkg::ST_IDLE &&
                 !rx_rd_in) begin
      full_q <= 1'b1;
    // reads that empty the FIFO clear it
    end else if (rx_pop && rx_cnt == 5'h1) begin
      full_q <= 1'b0;
    end
  end

  // error clear; frame errors set over it
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      ore_q <= 1'b0;
    end else begin
      if (done && f_err && !(rx_fifo_enable_in && err_any)) begin
        ferr_q <= 1'b1;
      end else if (rx_error_clear_in) begin
        ferr_q <= 1'b0;
      end
      // no parity check in multiprocessor mode
      if (done && p_err && !(rx_fifo_enable_in && err_any)) begin
        perr_q <= 1'b1;
      end else if (rx_error_clear_in) begin
        perr_q <= 1'b0;
      end
      // overrun against capacity or unread word
      if (done && (rx_fifo_enable_in ? (rx_cnt == 5'(`ASP_FIFO_DEPTH))
                                     : full_q)) begin
        ore_q <= 1'b1;
      end else if (rx_error_clear_in) begin
        ore_q <= 1'b0;
      end
    end
  end

  // registered views of data, flags, counts and requests
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rx_data_q <= '0;
      rx_ad_q <= 1'b0;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      txc_q <= '0;
      rxc_q <= '0;
    end else begin
      rx_data_q <= rx_fd & len_mask;
      if (done && multiproc_in) begin
        rx_ad_q <= rx_par_q;
      end
      tx_irq_q <= (tx_empty_flag_q & tx_irq_enable_in) |
                  (tbi_q & tx_idle_irq_enable_in) |
                  (fifo_tx_request_flag_q & fifo_tx_irq_enable_in);
      rx_irq_q <= (full_q | err_any) & rx_irq_enable_in;
      // count is zero only when empty
      txc_q <= tx_cnt;
      rxc_q <= rx_cnt;
    end
  end

  assign serial_out_line_out = sot_q;
  assign tx_wr_ready_out = tx_fr;
  assign rx_data_reg_out = rx_data_q;
  assign rx_ad_flag_out = rx_ad_q;
  assign tx_empty_flag_out = tx_empty_flag_q;
  assign tx_bus_idle_flag_out = tbi_q;
  assign fifo_tx_request_flag_out = fifo_tx_request_flag_q;
  assign rx_full_flag_out = full_q;
  assign overrun_flag_out = ore_q;
  assign framing_error_flag_out = ferr_q;
  assign parity_error_flag_out = perr_q;
  assign tx_fifo_byte_count_out = txc_q;
  assign rx_fifo_byte_count_out = rxc_q;
  assign tx_irq_out = tx_irq_q;
  assign rx_irq_out = rx_irq_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_tx_empty_load: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    tx_load |=> tx_empty_flag_q) else $error("empty flag not set on load");
  a_bus_idle_rel: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    tbi_q |-> $past(tx_empty_flag_q) && $past(tx_st_q) == asp_pkg::ST_IDLE)
    else $error("bus idle flag while busy");
  a_fifo_req_set: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    tx_fifo_enable_in && tx_cnt == '0 |=> fifo_tx_request_flag_q)
    else $error("request flag missing");
  a_fifo_req_full: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    tx_cnt == 5'h10 && !(tx_fifo_enable_in && tx_cnt == '0) |=> !fifo_tx_request_flag_q)
    else $error("request flag kept at full");
  a_count_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (txc_q == '0) == !$past(tx_fv)) else $error("count and empty disagree");
  a_start_bit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    tx_load |=> ##1 sot_q == line_inversion_in)
    else $error("start bit not driven");
  a_edge_only: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    rx_st_q == asp_pkg::ST_IDLE && !rx_fall |=> rx_st_q == asp_pkg::ST_IDLE)
    else $error("reception without edge");
  a_half_reload: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    rx_fall |=> rx_bc_q == (reload_val_in >> 1))
    else $error("baud counter not reloaded");
  a_full_stop: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    done && !rx_fifo_enable_in |=> full_q) else $error("full flag not set");
  a_err_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    rx_error_clear_in && !done |=> !ferr_q && !perr_q && !ore_q)
    else $error("errors not cleared");
  a_no_mp_parity: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    multiproc_in && !perr_q ##1 multiproc_in |-> !perr_q)
    else $error("parity error in multiprocessor mode");
endmodule : asp_top
`default_nettype wire

// ### dv/asp_remote.sv
/*
  Far serial device: sends frames to the port and captures its frames.
  Assumes reload 7 at 8 ns, so one bit lasts 64 ns.
*/
`timescale 1ns/10ps
`default_nettype none
module asp_remote (
  input wire logic line_in,
  output logic line_out
);
  logic line_inversion = 1'b0;
  realtime bit_t = 64.0;
  initial line_out = 1'b1;
  task automatic set_inv(input logic v);
    line_inversion = v;
    line_out = ~v;
  endtask : set_inv
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = f[i] ^ line_inversion;
      #(bit_t);
    end
    line_out = ~line_inversion;
  endtask : send
  // wait for start edge; sampling at the centre tolerates skew
  task automatic recv(output logic [12:0] f, input int n);
    f = '0;
    wait ((line_in ^ line_inversion) === 1'b1);
    wait ((line_in ^ line_inversion) === 1'b0);
    #(bit_t / 2);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in ^ line_inversion;
      #(bit_t);
    end
  endtask : recv
endmodule : asp_remote
`default_nettype wire

// ### dv/asp_top_tb.sv
/*
  Bench for the serial port: frames both ways, error flags, both FIFOs.
  Assumes asp_remote on the serial lines at 8 clocks per bit.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asp_cfg.svh"
module asp_top_tb;
  logic mclk_in = 1'b0, nrst_in = 1'b0, two_stop_in = 1'b0;
  logic [`ASP_RELOAD_W-1:0] reload_val_in = 15'h0007;
  logic tx_enable_in = 1'b1, rx_enable_in = 1'b1, parity_odd_in = 1'b0;
  logic [2:0] data_length_field_in = 3'h3;
  logic parity_enable_in = 1'b1, multiproc_in = 1'b0, tx_ad_flag_in = 1'b0;
  logic bit_direction_select_in = 1'b0, line_inversion_in = 1'b0;
  logic tx_fifo_enable_in = 1'b0, rx_fifo_enable_in = 1'b0;
  logic rx_fifo_idle_detect_enable_in = 1'b0, tx_irq_enable_in = 1'b0;
  logic [`ASP_CNT_W-1:0] rx_transfer_count_in = 5'h02;
  logic tx_idle_irq_enable_in = 1'b0, fifo_tx_irq_enable_in = 1'b0;
  logic rx_irq_enable_in = 1'b0, tx_wr_in = 1'b0, rx_rd_in = 1'b0;
  logic rx_error_clear_in = 1'b0, fifo_tx_request_clear_in = 1'b0;
  logic [`ASP_DATA_W-1:0] tx_data_in = 9'h000, rx_data_reg_out;
  logic tx_wr_ready_out, serial_in_line_in, serial_out_line_out;
  logic rx_ad_flag_out, tx_empty_flag_out, tx_bus_idle_flag_out;
  logic fifo_tx_request_flag_out, rx_full_flag_out, overrun_flag_out;
  logic framing_error_flag_out, parity_error_flag_out, tx_irq_out, rx_irq_out;
  logic [`ASP_CNT_W-1:0] tx_fifo_byte_count_out, rx_fifo_byte_count_out;
  logic [12:0] f, g;
  logic [2:0] lens [3] = '{3'h3, 3'h0, 3'h4};
  int fl, n, errors = 0, total_checks = 0, cyc = 0;
  asp_top i_asp_top (.mclk_in, .nrst_in, .reload_val_in, .tx_enable_in,
    .rx_enable_in, .data_length_field_in, .two_stop_in, .parity_enable_in,
    .parity_odd_in, .multiproc_in, .tx_ad_flag_in, .bit_direction_select_in,
    .line_inversion_in, .tx_fifo_enable_in, .rx_fifo_enable_in,
    .rx_fifo_idle_detect_enable_in, .rx_transfer_count_in, .tx_irq_enable_in,
    .tx_idle_irq_enable_in, .fifo_tx_irq_enable_in, .rx_irq_enable_in,
    .tx_wr_in, .tx_data_in, .tx_wr_ready_out, .rx_rd_in, .rx_error_clear_in,
    .fifo_tx_request_clear_in, .serial_in_line_in, .serial_out_line_out,
    .rx_data_reg_out, .rx_ad_flag_out, .tx_empty_flag_out,
    .tx_bus_idle_flag_out, .fifo_tx_request_flag_out, .rx_full_flag_out,
    .overrun_flag_out, .framing_error_flag_out, .parity_error_flag_out,
    .tx_fifo_byte_count_out, .rx_fifo_byte_count_out, .tx_irq_out,
    .rx_irq_out);
  asp_remote i_asp_remote (.line_in(serial_out_line_out),
    .line_out(serial_in_line_in));
  initial forever #4 mclk_in = ~mclk_in;
  // the run needs about 4000 cycles; fifteen times that means a hang
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [12:0] e,
                     input logic [12:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // expected frame, start bit first, from the current format inputs
  task automatic mk(input logic [8:0] d, input int k, input logic bad);
    logic p;
    p = parity_odd_in;
    f = '0;
    fl = k + 2 + int'(parity_enable_in);
    for (int i = 0; i < k; i++) begin
      f[i+1] = bit_direction_select_in ? d[k-1-i] : d[i];
      p ^= f[i+1];
    end
    if (parity_enable_in) f[k+1] = p ^ bad;
    f[fl-1] = 1'b1;
  endtask : mk
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    tick(4);
    nrst_in = 1'b1;
    chk("reset", 13'h1D, {tx_empty_flag_out, tx_bus_idle_flag_out,
      fifo_tx_request_flag_out, rx_full_flag_out, serial_out_line_out});
    tx_irq_enable_in = 1'b1;
    tick(2);
    chk("tx irq", 1, tx_irq_out);
    tx_irq_enable_in = 1'b0;
    // three formats, each sent out and then looped back in
    for (int k = 0; k < 3; k++) begin
      data_length_field_in = lens[k];
      bit_direction_select_in = (k == 1);
      parity_enable_in = (k < 2);
      parity_odd_in = (k == 1);
      line_inversion_in = (k == 2);
      two_stop_in = (k == 2);
      i_asp_remote.set_inv(k == 2);
      n = 5 + int'(lens[k]);
      tick(2);
      mk(9'h1A5 ^ 9'(k), n, 1'b0);
      // second stop bit is captured on the transmit side only
      if (two_stop_in) f[fl] = 1'b1;
      fork
        i_asp_remote.recv(g, fl + int'(two_stop_in));
        begin
          tx_data_in = 9'h1A5 ^ 9'(k);
          pulse(tx_wr_in);
          chk("empty at write", 0, tx_empty_flag_out);
        end
      join
      chk("tx frame", f, g);
      tick(8);
      chk("idle", 3, {tx_empty_flag_out, tx_bus_idle_flag_out});
      i_asp_remote.send(f, fl);
      tick(2);
      chk("rx word", {2'b10, (9'h1A5 ^ 9'(k)) & 9'((1 << n) - 1)},
        {rx_full_flag_out, parity_error_flag_out, rx_data_reg_out});
      pulse(rx_rd_in);
      tick(1);
      chk("rx read", 0, rx_full_flag_out);
    end
    data_length_field_in = 3'h3;
    parity_enable_in = 1'b1;
    parity_odd_in = 1'b0;
    line_inversion_in = 1'b0;
    two_stop_in = 1'b0;
    i_asp_remote.set_inv(1'b0);
    // let the new idle level settle before the next start bit
    tick(2);
    // bad parity, low stop bit, flag in the parity slot
    for (int k = 0; k < 3; k++) begin
      multiproc_in = (k == 2);
      mk(9'h03C, 8, k != 1);
      if (k == 1) f[fl-1] = 1'b0;
      i_asp_remote.send(f, fl);
      tick(2);
      chk("rx errors", {1'b1, k == 1, k == 0}, {rx_full_flag_out,
        framing_error_flag_out, parity_error_flag_out});
      if (k == 2) chk("ad flag", 1, rx_ad_flag_out);
      pulse(rx_error_clear_in);
      pulse(rx_rd_in);
      tick(1);
      chk("cleared", 0, {rx_full_flag_out, framing_error_flag_out,
        parity_error_flag_out});
    end
    multiproc_in = 1'b0;
    tx_enable_in = 1'b0;
    tx_fifo_enable_in = 1'b1;
    fifo_tx_irq_enable_in = 1'b1;
    tx_wr_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      tx_data_in = 9'(i);
      tick(1);
    end
    tx_wr_in = 1'b0;
    tick(2);
    chk("tx fifo full", 13'h080, {tx_fifo_byte_count_out,
      fifo_tx_request_flag_out, tx_wr_ready_out, tx_irq_out});
    pulse(fifo_tx_request_clear_in);
    tx_enable_in = 1'b1;
    for (int i = 0; i < 3000 && tx_bus_idle_flag_out !== 1'b1; i++) tick(1);
    chk("tx fifo empty", 13'h007, {tx_fifo_byte_count_out,
      tx_bus_idle_flag_out, fifo_tx_request_flag_out,
      tx_irq_out});
    fifo_tx_irq_enable_in = 1'b0;
    rx_fifo_enable_in = 1'b1;
    rx_irq_enable_in = 1'b1;
    mk(9'h055, 8, 1'b0);
    for (int i = 0; i < 17; i++) begin
      i_asp_remote.send(f, fl);
      tick(3);
      if (i == 0) chk("one frame", 13'h001, {rx_full_flag_out,
        rx_fifo_byte_count_out});
    end
    chk("overrun", 13'h0F0, {rx_full_flag_out, overrun_flag_out,
      rx_irq_out, rx_fifo_byte_count_out});
    pulse(rx_error_clear_in);
    rx_rd_in = 1'b1;
    tick(16);
    rx_rd_in = 1'b0;
    tick(2);
    chk("drained", 0, {rx_full_flag_out, overrun_flag_out,
      rx_fifo_byte_count_out});
    // one frame below the transfer count, then eight idle bit times
    rx_fifo_idle_detect_enable_in = 1'b1;
    i_asp_remote.send(f, fl);
    tick(40);
    chk("idle early", 0, rx_full_flag_out);
    tick(40);
    chk("idle timeout", 13'h021, {rx_full_flag_out,
      rx_fifo_byte_count_out});
    report_and_stop();
  end
endmodule : asp_top_tb
`default_nettype wire
